// ==== fsc_map.svh ====
// Purpose: Address map, field positions and reset values of the serial control slice
// Assumes: Byte addresses on the register port, one 32-bit word per register
// Notes:   Definitions only
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
// ============================================================
// Register addresses
`define FSC_A_CTRL        32'hf8034200
`define FSC_A_MODE        32'hf8034204
`define FSC_A_IEN         32'hf8034208
`define FSC_A_IDIS        32'hf803420c
`define FSC_A_IMR         32'hf8034210
`define FSC_A_STAT        32'hf8034214
`define FSC_A_BAUD        32'hf8034220
`define FSC_A_RTO         32'hf8034224
`define FSC_A_TTGR        32'hf8034228
`define FSC_A_WPMR        32'hf80342e4
`define FSC_A_THR         32'hf8034634
`define FSC_A_SMBTR       32'hf8034638
`define FSC_A_FMR         32'hf8034650
// ============================================================
// Control strobe bits
`define FSC_B_ARM         11
`define FSC_B_RESTART     15
`define FSC_B_RTS_ON      18
`define FSC_B_RTS_OFF     19
`define FSC_B_LIN_ABT     20
`define FSC_B_LIN_WAKE    21
// ============================================================
// Mode field values
`define FSC_MODE_HW_HS    4'h2
`define FSC_MODE_NORMAL   4'h0
`define FSC_MODE_SPI_M    4'he
`define FSC_MODE_SPI_S    4'hf
// ============================================================
// Interrupt layout, shared by status and mask
`define FSC_I_RX_READY_MASK       0
`define FSC_I_TX_READY_MASK       1
`define FSC_I_OVR         5
`define FSC_I_TIMEOUT     8
`define FSC_I_TX_EMPTY_MASK     9
`define FSC_I_UNR         10
`define FSC_I_CSEDGE      19
`define FSC_I_CMP         22
`define FSC_I_SEXT        24
`define FSC_I_MEXT        25
`define FSC_I_HMAX        26
`define FSC_SPI_BITS      32'h00480623
`define FSC_IMPL_BITS     32'h07480723
// ============================================================
// Other fields and reset values
`define FSC_B_WRITE_PROTECT_ENABLE        0
`define FSC_B_FIFO_ENABLE_CMD      4
`define FSC_TG_MSB        7
`define FSC_SMBUS_PRESCALE_MSB     3
`define FSC_SEXT_LSB      8
`define FSC_MEXT_LSB      16
`define FSC_HMAX_LSB      24
`define FSC_BAUD_RST      16'h0001
`define FSC_RTS_RST       1'b1
`define FSC_BYTES_ONE     3'h1
`define FSC_BYTES_FOUR    3'h4
`endif

// ==== fsc_peer.sv ====
// Purpose: Serial line peer: engine events and two-wire clock line levels
// Assumes: Called from the bench between clock edges
// Notes:   Pulses last one cycle, levels hold until changed
`timescale 1ns/1ps
module fsc_peer (
    // Clock
    input  wire logic  clock_i,
    // Toward the block
    output logic [6:0] evt_o,
    output logic       rx_char_o,
    output logic       tx_done_o,
    output logic [2:0] scl_o
);
    initial begin
        evt_o     = 7'h00;
        rx_char_o = 1'b0;
        tx_done_o = 1'b0;
        scl_o     = 3'h0;
    end
    // ============
    // One-cycle event pulse; returns once the block has seen it
    task automatic pulse(input logic [8:0] v);
        @(posedge clock_i);
        {tx_done_o, rx_char_o, evt_o} <= v;
        @(posedge clock_i);
        {tx_done_o, rx_char_o, evt_o} <= 9'h000;
        #1;
    endtask
    task automatic line(input logic [2:0] v);
        @(posedge clock_i);
        scl_o <= v;
    endtask
endmodule // fsc_peer

// ==== fsc_pkg.sv ====
// Purpose: Shared types of the serial control slice
// Assumes: Nothing
// Notes:   Numbers live in fsc_map.svh
package fsc_pkg;
    typedef logic [31:0] fsc_word_t;
    typedef logic [3:0]  fsc_mode_t;
    typedef enum logic [1:0] {
        FSC_TO_IDLE,
        FSC_TO_WAIT,
        FSC_TO_RUN
    } fsc_to_state_t;
endpackage

// ==== fsc_regs.sv ====
// Purpose: Register slice of a multi-protocol serial unit (USART, LIN, SPI, two-wire)
// Assumes: Single clock; all inputs synchronous; ce_i low freezes every flip-flop
// Notes:   Read data appear in the cycle after the read strobe only
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "fsc_map.svh"

module fsc_regs (
    // Clock, reset, enable
    input  wire logic                 clock_i,
    input  wire logic                 rstn_i,
    input  wire logic                 ce_i,
    // Register port
    input  wire fsc_pkg::fsc_word_t   addr_i,
    input  wire fsc_pkg::fsc_word_t   wdata_i,
    input  wire logic                 we_i,
    input  wire logic                 re_i,
    output logic [31:0]               rdata_o,
    // Serial engine events, one-cycle pulses
    input  wire logic                 rx_ready_evt_i,
    input  wire logic                 tx_ready_evt_i,
    input  wire logic                 overrun_evt_i,
    input  wire logic                 tx_empty_evt_i,
    input  wire logic                 underrun_evt_i,
    input  wire logic                 cs_edge_evt_i,
    input  wire logic                 compare_evt_i,
    input  wire logic                 rx_char_i,
    input  wire logic                 tx_char_done_i,
    // Two-wire clock line state, levels
    input  wire logic                 scl_slave_low_i,
    input  wire logic                 scl_master_low_i,
    input  wire logic                 scl_high_i,
    // Outputs to serial engine and pins
    output logic                      irq_o,
    output logic                      rts_o,
    output logic                      lin_abort_o,
    output logic                      lin_wakeup_o,
    output logic                      tx_hold_o,
    output logic [31:0]               twi_tx_data_o,
    output logic [2:0]                twi_tx_bytes_o,
    output logic                      twi_tx_valid_o,
    output logic                      bus_free_o
);
    import fsc_pkg::*;

    // ============================================================
    // Decode
    function automatic logic hit(input fsc_word_t a, input fsc_word_t ref_a);
        hit = (a == ref_a);
    endfunction

    wire wr_ctrl  = we_i && hit(addr_i, `FSC_A_CTRL);
    wire wr_mode  = we_i && hit(addr_i, `FSC_A_MODE);
    wire wr_ien   = we_i && hit(addr_i, `FSC_A_IEN);
    wire wr_idis  = we_i && hit(addr_i, `FSC_A_IDIS);
    wire wr_stat  = we_i && hit(addr_i, `FSC_A_STAT);
    wire wr_baud  = we_i && hit(addr_i, `FSC_A_BAUD);
    wire wr_rto   = we_i && hit(addr_i, `FSC_A_RTO);
    wire wr_wpmr  = we_i && hit(addr_i, `FSC_A_WPMR);
    wire wr_thr   = we_i && hit(addr_i, `FSC_A_THR);
    wire wr_smbtr = we_i && hit(addr_i, `FSC_A_SMBTR);
    wire wr_fmr   = we_i && hit(addr_i, `FSC_A_FMR);

    // ============================================================
    // Configuration registers
    fsc_mode_t   mode_reg;
    logic        write_protect_enable_reg;
    logic [7:0]  tg_reg;
    logic [15:0] baud_reg;
    logic [15:0] rto_reg;
    fsc_word_t   smbtr_reg;
    logic        fifo_en_reg;
    logic [1:0]  tx_ready_level_mode_reg;
    fsc_word_t   imr_reg;
    fsc_word_t   stat_reg;

    // Protection locks only the timeguard; the lock bit itself stays writable
    wire wr_ttgr = we_i && hit(addr_i, `FSC_A_TTGR) && !write_protect_enable_reg;

    wire spi_mode = (mode_reg == `FSC_MODE_SPI_M) || (mode_reg == `FSC_MODE_SPI_S);

    wire [7:0] tg_next = wr_ttgr ? wdata_i[`FSC_TG_MSB:0] : tg_reg;

    // Enable sets, disable clears; a bit in both writes is left set
    wire [31:0] imr_next = ((imr_reg & ~({32{wr_idis}} & wdata_i)) | ({32{wr_ien}} & wdata_i))
                           & `FSC_IMPL_BITS;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg    <= `FSC_MODE_NORMAL;
            write_protect_enable_reg    <= 1'b0;
            tg_reg      <= 8'h00;
            baud_reg    <= `FSC_BAUD_RST;
            rto_reg     <= 16'h0000;
            smbtr_reg   <= 32'h00000000;
            fifo_en_reg <= 1'b0;
            tx_ready_level_mode_reg  <= 2'h0;
            imr_reg     <= 32'h00000000;
        end else if (ce_i) begin
            if (wr_mode) mode_reg <= wdata_i[3:0];
            if (wr_wpmr) write_protect_enable_reg <= wdata_i[`FSC_B_WRITE_PROTECT_ENABLE];
            tg_reg  <= tg_next;
            if (wr_baud) baud_reg <= wdata_i[15:0];
            if (wr_rto) rto_reg <= wdata_i[15:0];
            if (wr_smbtr) smbtr_reg <= wdata_i;
            if (wr_fmr) begin
                fifo_en_reg <= wdata_i[`FSC_B_FIFO_ENABLE_CMD];
                tx_ready_level_mode_reg  <= wdata_i[1:0];
            end
            imr_reg <= imr_next;
        end
    end

    // ============================================================
    // Control strobes
    wire cmd_arm     = wr_ctrl && wdata_i[`FSC_B_ARM];
    wire cmd_restart = wr_ctrl && wdata_i[`FSC_B_RESTART];
    wire cmd_rts_on  = wr_ctrl && wdata_i[`FSC_B_RTS_ON];
    wire cmd_rts_off = wr_ctrl && wdata_i[`FSC_B_RTS_OFF];

    // In other modes rts_o keeps its value and the commands do nothing
    logic rts_next;
    always_comb begin
        rts_next = rts_o;
        if (mode_reg == `FSC_MODE_HW_HS) begin
            if (cmd_rts_on) rts_next = 1'b1;
            if (cmd_rts_off) rts_next = 1'b0;
        end else if (mode_reg == `FSC_MODE_NORMAL) begin
            if (cmd_rts_on) rts_next = 1'b0;
            if (cmd_rts_off) rts_next = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rts_o        <= `FSC_RTS_RST;
            lin_abort_o  <= 1'b0;
            lin_wakeup_o <= 1'b0;
        end else if (ce_i) begin
            rts_o        <= rts_next;
            lin_abort_o  <= wr_ctrl && wdata_i[`FSC_B_LIN_ABT];
            lin_wakeup_o <= wr_ctrl && wdata_i[`FSC_B_LIN_WAKE];
        end
    end

    // ============================================================
    // Bit period tick, divisor zero treated as one
    logic [15:0] baud_cnt_reg;
    wire bit_tick = (baud_cnt_reg + 16'h0001 >= baud_reg);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) baud_cnt_reg <= 16'h0000;
        else if (ce_i) baud_cnt_reg <= bit_tick ? 16'h0000 : baud_cnt_reg + 16'h0001;
    end

    // ============================================================
    // Receive timeout, counted in bit periods
    fsc_to_state_t to_state_reg;
    fsc_to_state_t to_state_next;
    logic [15:0]   to_cnt_reg;
    logic [15:0]   to_cnt_next;
    logic          to_evt;

    always_comb begin
        to_state_next = to_state_reg;
        to_cnt_next   = to_cnt_reg;
        to_evt        = 1'b0;
        case (to_state_reg)
            FSC_TO_IDLE: ;
            FSC_TO_WAIT: begin
                if (rx_char_i) begin
                    to_state_next = FSC_TO_RUN;
                    to_cnt_next   = rto_reg;
                end
            end
            FSC_TO_RUN: begin
                if (rx_char_i) begin
                    to_cnt_next = rto_reg;
                end else if (bit_tick) begin
                    if (to_cnt_reg <= 16'h0001) begin
                        to_evt        = 1'b1;
                        to_state_next = FSC_TO_IDLE;
                    end else begin
                        to_cnt_next = to_cnt_reg - 16'h0001;
                    end
                end
            end
            default: to_state_next = FSC_TO_IDLE;
        endcase
        if (cmd_arm) begin
            to_state_next = FSC_TO_WAIT;
            to_evt        = 1'b0;
        end else if (cmd_restart) begin
            to_state_next = FSC_TO_RUN;
            to_cnt_next   = rto_reg;
        end
        if (rto_reg == 16'h0000) begin
            to_state_next = FSC_TO_IDLE;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            to_state_reg <= FSC_TO_IDLE;
            to_cnt_reg   <= 16'h0000;
        end else if (ce_i) begin
            to_state_reg <= to_state_next;
            to_cnt_reg   <= to_cnt_next;
        end
    end

    // ============================================================
    // Transmit timeguard: hold the transmitter idle after each character
    logic [7:0] tg_cnt_reg;
    wire tg_load = tx_char_done_i && (tg_reg != 8'h00);
    wire tg_dec  = bit_tick && (tg_cnt_reg != 8'h00);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tg_cnt_reg <= 8'h00;
            tx_hold_o  <= 1'b0;
        end else if (ce_i) begin
            if (tg_load) begin
                tg_cnt_reg <= tg_reg;
                tx_hold_o  <= 1'b1;
            end else if (tg_dec) begin
                tg_cnt_reg <= tg_cnt_reg - 8'h01;
                tx_hold_o  <= (tg_cnt_reg != 8'h01);
            end
        end
    end

    // ============================================================
    // Two-wire transmit holding, all four lanes only in FIFO multi-data mode
    wire [2:0] thr_bytes = (fifo_en_reg && (tx_ready_level_mode_reg != 2'h0)) ? `FSC_BYTES_FOUR : `FSC_BYTES_ONE;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            twi_tx_data_o  <= 32'h00000000;
            twi_tx_bytes_o <= 3'h0;
            twi_tx_valid_o <= 1'b0;
        end else if (ce_i) begin
            twi_tx_valid_o <= wr_thr;
            if (wr_thr) begin
                twi_tx_data_o  <= wdata_i;
                twi_tx_bytes_o <= thr_bytes;
            end
        end
    end

    // ============================================================
    // SMBus prescaler: tick every 2^(n+1) clocks
    logic [16:0] smbus_prescale_cnt_reg;
    wire [3:0]  smbus_prescale     = smbtr_reg[`FSC_SMBUS_PRESCALE_MSB:0];
    wire [16:0] smbus_prescale_top = (17'h00002 << smbus_prescale) - 17'h00001;
    wire        smb_tick  = (smbus_prescale_cnt_reg >= smbus_prescale_top);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) smbus_prescale_cnt_reg <= 17'h00000;
        else if (ce_i) smbus_prescale_cnt_reg <= smb_tick ? 17'h00000 : smbus_prescale_cnt_reg + 17'h00001;
    end

    // Slave stretch, master stretch and clock-high counters share one shape
    wire [2:0] lvl = {scl_high_i, scl_master_low_i, scl_slave_low_i};
    wire [7:0] lim [3] = '{smbtr_reg[`FSC_SEXT_LSB +: 8], smbtr_reg[`FSC_MEXT_LSB +: 8],
                           smbtr_reg[`FSC_HMAX_LSB +: 8]};
    logic [2:0] lim_hit;
    logic [2:0] lim_evt;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_limit
            logic [7:0] cnt_reg;
            logic       done_reg;
            // A zero limit disables the stretch checks; the high limit has no off value
            wire armed = (g == 2) || (lim[g] != 8'h00);
            wire reach = lvl[g] && armed && (cnt_reg >= lim[g]);
            assign lim_hit[g] = reach;
            assign lim_evt[g] = reach && !done_reg;
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cnt_reg  <= 8'h00;
                    done_reg <= 1'b0;
                end else if (ce_i) begin
                    if (!lvl[g]) begin
                        cnt_reg  <= 8'h00;
                        done_reg <= 1'b0;
                    end else begin
                        if (smb_tick && cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h01;
                        if (reach) done_reg <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ============================================================
    // Sticky status, write one to clear; a new event beats the clear
    logic [31:0] evt;
    always_comb begin
        evt                 = 32'h00000000;
        evt[`FSC_I_RX_READY_MASK]   = rx_ready_evt_i;
        evt[`FSC_I_TX_READY_MASK]   = tx_ready_evt_i;
        evt[`FSC_I_OVR]     = overrun_evt_i;
        evt[`FSC_I_TIMEOUT] = to_evt;
        evt[`FSC_I_TX_EMPTY_MASK] = tx_empty_evt_i;
        evt[`FSC_I_UNR]     = underrun_evt_i;
        evt[`FSC_I_CSEDGE]  = cs_edge_evt_i;
        evt[`FSC_I_CMP]     = compare_evt_i;
        evt[`FSC_I_SEXT]    = lim_evt[0];
        evt[`FSC_I_MEXT]    = lim_evt[1];
        evt[`FSC_I_HMAX]    = lim_evt[2];
    end

    wire [31:0] w1c       = {32{wr_stat}} & wdata_i;
    wire [31:0] arm_clr   = cmd_arm ? (32'h1 << `FSC_I_TIMEOUT) : 32'h00000000;
    wire [31:0] stat_next = ((stat_reg & ~w1c & ~arm_clr) | evt) & `FSC_IMPL_BITS;

    // SPI interrupt bits count only while an SPI mode is selected
    wire [31:0] mask_eff  = spi_mode ? imr_reg : (imr_reg & ~`FSC_SPI_BITS);
    wire        irq_next  = |(stat_next & mask_eff);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_reg   <= 32'h00000000;
            irq_o      <= 1'b0;
            bus_free_o <= 1'b0;
        end else if (ce_i) begin
            stat_reg   <= stat_next;
            irq_o      <= irq_next;
            bus_free_o <= lim_hit[2];
        end
    end

    // ============================================================
    // Read path
    wire [31:0] imr_spi_view = spi_mode ? (imr_reg & `FSC_SPI_BITS) : 32'h00000000;
    logic [31:0] rd_mux;
    always_comb begin
        case (addr_i)
            `FSC_A_MODE:  rd_mux = {28'h0000000, mode_reg};
            `FSC_A_IMR:   rd_mux = imr_spi_view | (imr_reg & ~`FSC_SPI_BITS);
            `FSC_A_STAT:  rd_mux = stat_reg;
            `FSC_A_BAUD:  rd_mux = {16'h0000, baud_reg};
            `FSC_A_RTO:   rd_mux = {16'h0000, rto_reg};
            `FSC_A_TTGR:  rd_mux = {24'h000000, tg_reg};
            `FSC_A_WPMR:  rd_mux = {31'h00000000, write_protect_enable_reg};
            `FSC_A_SMBTR: rd_mux = {smbtr_reg[31:8], 4'h0, smbtr_reg[3:0]};
            `FSC_A_FMR:   rd_mux = {27'h0000000, fifo_en_reg, 2'h0, tx_ready_level_mode_reg};
            default:      rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) rdata_o <= 32'h00000000;
        else if (ce_i) rdata_o <= re_i ? rd_mux : 32'h00000000;
    end

endmodule // fsc_regs

// ==== fsc_regs_sva.sv ====
// Purpose: Concurrent checks on the ports of the serial control slice
// Assumes: One clock; mode, protect and timeguard shadowed from bus writes
// Notes:   Bound to fsc_regs below
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_regs_sva (
    // Clock and reset
    input wire logic               clock_i,
    input wire logic               rstn_i,
    input wire logic               ce_i,
    // Register port
    input wire fsc_pkg::fsc_word_t addr_i,
    input wire fsc_pkg::fsc_word_t wdata_i,
    input wire logic               we_i,
    input wire logic               re_i,
    input wire logic [31:0]        rdata_o,
    // Line side
    input wire logic               tx_char_done_i,
    input wire logic               scl_high_i,
    input wire logic               rts_o,
    input wire logic               lin_abort_o,
    input wire logic               lin_wakeup_o,
    input wire logic               tx_hold_o,
    input wire logic [31:0]        twi_tx_data_o,
    input wire logic               twi_tx_valid_o,
    input wire logic               bus_free_o
);
    import fsc_pkg::*;
    fsc_mode_t  mode_reg;
    logic       wp_reg;
    logic [7:0] tg_reg;
    logic       wr_ok;
    logic       ctrl_wr;
    assign wr_ok   = we_i && ce_i;
    assign ctrl_wr = wr_ok && addr_i == `FSC_A_CTRL;
    // ============
    // Shadow registers; timeguard shadow honours write protect
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= 4'h0;
            wp_reg   <= 1'b0;
            tg_reg   <= 8'h00;
        end else if (wr_ok) begin
            if (addr_i == `FSC_A_MODE)
                mode_reg <= wdata_i[3:0];
            if (addr_i == `FSC_A_WPMR)
                wp_reg <= wdata_i[`FSC_B_WRITE_PROTECT_ENABLE];
            if (addr_i == `FSC_A_TTGR && !wp_reg)
                tg_reg <= wdata_i[7:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // ============
    // Checks
    a_rts_assert: assert property (
        ctrl_wr && wdata_i[`FSC_B_RTS_ON] && !wdata_i[`FSC_B_RTS_OFF] && (mode_reg == 4'h2 || mode_reg == 4'h0)
        |=> rts_o == ($past(mode_reg) == 4'h2)) else $error("rts wrong after assert command");
    a_rts_deassert: assert property (
        ctrl_wr && wdata_i[`FSC_B_RTS_OFF] && (mode_reg == 4'h2 || mode_reg == 4'h0)
        |=> rts_o == ($past(mode_reg) == 4'h0)) else $error("rts wrong after deassert command");
    a_lin_abort: assert property (
        ctrl_wr && wdata_i[`FSC_B_LIN_ABT] |=> lin_abort_o) else $error("abort pulse missing");
    a_abort_quiet: assert property (
        ce_i && !(ctrl_wr && wdata_i[`FSC_B_LIN_ABT]) |=> !lin_abort_o) else $error("abort pulse unasked");
    a_lin_wake: assert property (
        ctrl_wr && wdata_i[`FSC_B_LIN_WAKE] |=> lin_wakeup_o) else $error("wakeup pulse missing");
    a_thr_push: assert property (
        wr_ok && addr_i == `FSC_A_THR |=> twi_tx_valid_o && twi_tx_data_o == $past(wdata_i))
        else $error("holding write not passed on");
    a_imr_hidden: assert property (
        re_i && ce_i && addr_i == `FSC_A_IMR && mode_reg < 4'he |=> (rdata_o & `FSC_SPI_BITS) == 32'h0)
        else $error("spi mask bits shown outside spi mode");
    a_guard_off: assert property (
        ce_i && tx_char_done_i && tg_reg == 8'h00 && !tx_hold_o |=> !tx_hold_o) else $error("hold with guard off");
    a_guard_on: assert property (
        ce_i && tx_char_done_i && tg_reg != 8'h00 |=> tx_hold_o) else $error("hold missing after character");
    a_free_high: assert property (
        bus_free_o && $past(ce_i) |-> $past(scl_high_i)) else $error("bus free while clock line low");
endmodule // fsc_regs_sva

bind fsc_regs fsc_regs_sva fsc_regs_sva_inst (
    .clock_i, .rstn_i, .ce_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .tx_char_done_i, .scl_high_i,
    .rts_o, .lin_abort_o, .lin_wakeup_o, .tx_hold_o, .twi_tx_data_o, .twi_tx_valid_o, .bus_free_o
);

// ==== fsc_tb.sv ====
// Purpose: Register-level bench of the serial control slice
// Assumes: fsc_peer plays the line side; clock enable held high except during the one frozen control write
// Notes:   Counting checks allow for the partial first tick
`timescale 1ns/1ps
`include "fsc_map.svh"
module tb;
    import fsc_pkg::*;
    logic        clock_i = 1'b0;
    logic        rstn_i  = 1'b0;
    logic        ce_i    = 1'b1;
    fsc_word_t   addr_i  = 32'h0;
    fsc_word_t   wdata_i = 32'h0;
    logic        we_i    = 1'b0;
    logic        re_i    = 1'b0;
    logic [31:0] rdata_o;
    logic [31:0] twi_tx_data_o;
    logic [2:0]  twi_tx_bytes_o;
    logic [6:0]  evt;
    logic [2:0]  scl;
    logic        rx_char, tx_done, rts_e;
    logic        irq_o, rts_o, lin_abort_o, lin_wakeup_o, tx_hold_o, twi_tx_valid_o, bus_free_o;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          n;
    fsc_word_t   modes [4]  = '{32'h2, 32'h1, 32'h0, 32'h3};

    always #2 clock_i = ~clock_i;

    fsc_peer fsc_peer_inst (.clock_i, .evt_o(evt), .rx_char_o(rx_char), .tx_done_o(tx_done), .scl_o(scl));
    fsc_regs fsc_regs_inst (
        .clock_i, .rstn_i, .ce_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
        .rx_ready_evt_i(evt[0]), .tx_ready_evt_i(evt[1]), .overrun_evt_i(evt[2]), .tx_empty_evt_i(evt[3]),
        .underrun_evt_i(evt[4]), .cs_edge_evt_i(evt[5]), .compare_evt_i(evt[6]),
        .rx_char_i(rx_char), .tx_char_done_i(tx_done),
        .scl_slave_low_i(scl[0]), .scl_master_low_i(scl[1]), .scl_high_i(scl[2]),
        .irq_o, .rts_o, .lin_abort_o, .lin_wakeup_o, .tx_hold_o, .twi_tx_data_o, .twi_tx_bytes_o,
        .twi_tx_valid_o, .bus_free_o
    );
    // ============
    // Bus tasks and comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input fsc_word_t a, input fsc_word_t d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clock_i);
        we_i <= 1'b0;
        #1;
    endtask
    task automatic rchk(input string nm, input fsc_word_t a, input fsc_word_t e);
        @(posedge clock_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clock_i);
        re_i <= 1'b0;
        #1;
        chk(nm, e, rdata_o);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard, about 100k cycles
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
    // ============
    // Scenarios
    initial begin
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        chk("rts_rst", 1'b1, rts_o);
        rchk("tg_rst", `FSC_A_TTGR, 32'h0);
        rchk("smb_rst", `FSC_A_SMBTR, 32'h0);
        rchk("unmapped", 32'hf80340f0, 32'h0);
        rts_e = 1'b1;
        foreach (modes[i]) begin
            wr(`FSC_A_MODE, modes[i]);
            for (int on = 0; on < 2; on++) begin
                wr(`FSC_A_CTRL, on ? 32'h1 << `FSC_B_RTS_ON : 32'h1 << `FSC_B_RTS_OFF);
                if (modes[i] == 32'h2)
                    rts_e = on[0];
                else if (modes[i] == 32'h0)
                    rts_e = !on[0];
                chk("rts", rts_e, rts_o);
            end
        end
        wr(`FSC_A_CTRL, 32'h1 << `FSC_B_LIN_ABT);
        chk("abort", 2'b01, {lin_wakeup_o, lin_abort_o});
        wr(`FSC_A_CTRL, 32'h1 << `FSC_B_LIN_WAKE);
        chk("wake", 2'b10, {lin_wakeup_o, lin_abort_o});
        @(posedge clock_i) ce_i <= 1'b0;
        wr(`FSC_A_CTRL, 32'h1 << `FSC_B_LIN_ABT);
        chk("frozen", 3'b000, {lin_wakeup_o, lin_abort_o, rts_o});
        ce_i <= 1'b1;
        wr(`FSC_A_CTRL, 32'h0);
        chk("ctrl_zero", 3'b000, {lin_wakeup_o, lin_abort_o, rts_o});
        // Mask view and interrupt gating; mode is 3 here
        wr(`FSC_A_IEN, 32'hffffffff);
        rchk("imr_usart", `FSC_A_IMR, `FSC_IMPL_BITS & ~`FSC_SPI_BITS);
        wr(`FSC_A_MODE, 32'he);
        rchk("imr_spi", `FSC_A_IMR, `FSC_IMPL_BITS);
        wr(`FSC_A_MODE, 32'hf);
        wr(`FSC_A_IDIS, 32'h1);
        rchk("imr_idis", `FSC_A_IMR, `FSC_IMPL_BITS & ~32'h1);
        fsc_peer_inst.pulse(9'h001);
        chk("irq_masked", 1'b0, irq_o);
        fsc_peer_inst.pulse(9'h07e);
        chk("irq_on", 1'b1, irq_o);
        wr(`FSC_A_MODE, 32'h0);
        tick(1);
        chk("irq_usart", 1'b0, irq_o);
        wr(`FSC_A_STAT, `FSC_SPI_BITS);
        rchk("stat_clr", `FSC_A_STAT, 32'h0);
        // Timeguard, write protect and hold length with a bit period of 4 clocks
        wr(`FSC_A_TTGR, 32'hffffff05);
        rchk("tg", `FSC_A_TTGR, 32'h5);
        wr(`FSC_A_WPMR, 32'h1);
        wr(`FSC_A_TTGR, 32'h9);
        rchk("tg_wp", `FSC_A_TTGR, 32'h5);
        wr(`FSC_A_WPMR, 32'h0);
        wr(`FSC_A_BAUD, 32'h4);
        fsc_peer_inst.pulse(9'h100);
        for (n = 0; tx_hold_o === 1'b1 && n < 100; n++)
            tick(1);
        chk("tg_len", 1'b1, n >= 16 && n <= 21);
        wr(`FSC_A_TTGR, 32'h0);
        fsc_peer_inst.pulse(9'h100);
        chk("tg_off", 1'b0, tx_hold_o);
        // Receive timeout: 3 bit periods of 4 clocks
        wr(`FSC_A_RTO, 32'h3);
        wr(`FSC_A_CTRL, 32'h1 << `FSC_B_RESTART);
        tick(5);
        rchk("to_early", `FSC_A_STAT, 32'h0);
        tick(10);
        rchk("to_hit", `FSC_A_STAT, 32'h100);
        wr(`FSC_A_CTRL, 32'h1 << `FSC_B_ARM);
        rchk("arm_clr", `FSC_A_STAT, 32'h0);
        tick(20);
        rchk("arm_wait", `FSC_A_STAT, 32'h0);
        fsc_peer_inst.pulse(9'h080);
        tick(16);
        rchk("arm_hit", `FSC_A_STAT, 32'h100);
        // Holding register lanes
        wr(`FSC_A_FMR, 32'h11);
        wr(`FSC_A_THR, 32'ha1b2c3d4);
        chk("thr_data", 32'ha1b2c3d4, twi_tx_data_o);
        chk("thr_four", 4'hc, {twi_tx_valid_o, twi_tx_bytes_o});
        rchk("thr_wo", `FSC_A_THR, 32'h0);
        wr(`FSC_A_FMR, 32'h0);
        wr(`FSC_A_THR, 32'h5a);
        chk("thr_one", 4'h9, {twi_tx_valid_o, twi_tx_bytes_o});
        // SMBus: tick every 4 clocks, slave limit 4, master off, high limit 3
        wr(`FSC_A_SMBTR, 32'h030004f1);
        rchk("smb", `FSC_A_SMBTR, 32'h03000401);
        wr(`FSC_A_STAT, 32'hffffffff);
        fsc_peer_inst.line(3'b011);
        tick(8);
        rchk("sext_early", `FSC_A_STAT, 32'h0);
        tick(10);
        rchk("sext", `FSC_A_STAT, 32'h1 << `FSC_I_SEXT);
        fsc_peer_inst.line(3'b100);
        tick(6);
        chk("free_early", 1'b0, bus_free_o);
        tick(12);
        chk("free", 1'b1, bus_free_o);
        rchk("hmax", `FSC_A_STAT, 32'h05000000);
        give_verdict();
    end
endmodule // tb
